// ### tcm_cfg.svh
// Offsets, field positions, reset values and counter widths of the channel 1/2 mode block.
`ifndef TCM_CFG_SVH
`define TCM_CFG_SVH

// =============================================================
// Register byte offsets on the AHB-Lite slave.
`define TCM_OFF_MODE      8'h00
`define TCM_OFF_ENABLE    8'h04
`define TCM_OFF_IRQ_STAT  8'h08
`define TCM_OFF_IRQ_MASK  8'h0C
`define TCM_OFF_STATE     8'h10

// =============================================================
// Reset values.
`define TCM_MODE_RST      16'h0000
`define TCM_ENABLE_RST    2'h0
`define TCM_IRQ_RST       4'h0

// =============================================================
// Field positions and widths.
`define TCM_CH_STRIDE     8
`define TCM_SEL_W         2
`define TCM_IRQ_CAP_LSB   0
`define TCM_IRQ_CLR_LSB   2
`define TCM_HSIZE_WORD    3'h2

// =============================================================
// Sampling divider and counter widths.
`define TCM_DIV_W         5
`define TCM_FLEN_W        4
`define TCM_PSC_W         3

`endif

// ### tcm_chan12_mode.sv
// Channel 1/2 mode configuration, input filters, capture prescalers and compare references.
//
// Decided for this implementation: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "tcm_cfg.svh"

// How it works
// - Channel 1 clear enable: high external trigger forces channel 1 reference low.
// - Channel 2 select: output, timer input two, timer input one, internal trigger.
// - Select fields are writable only while the channel's enable bit is zero.
// - Channel 1 select: output, timer input one, timer input two, internal trigger.
// - Capture prescaler captures once every 1, 2, 4 or 8 qualified events.
// - Filter code zero samples every clock with no qualification.
// - Filter codes pick sampling divider DIV and length N from the table.
// - Channel 2 prescaler in bits 11:10, filter in bits 15:12, as channel 1.
// - Channel 2 fast, preload, mode, clear in bits 10, 11, 14:12, 15.
// - Compare modes: frozen, set, clear, toggle, force low, force high, two PWM.
module tcm_chan12_mode
    import tcm_pkg::*;
(
    input  wire logic        i_clk_sys,
    input  wire logic        i_rstn,
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic      [31:0] o_hrdata,
    output logic             o_hreadyout,
    output logic             o_hresp,
    input  wire logic        i_timer_input_one,
    input  wire logic        i_timer_input_two,
    input  wire logic        i_internal_trigger_source,
    input  wire logic        i_filtered_ext_trigger,
    input  wire logic [1:0]  i_ch_match,
    input  wire logic [1:0]  i_ch_cnt_below,
    output logic             o_ch1_compare_ref,
    output logic             o_ch2_compare_ref,
    output logic             o_capture_input_one,
    output logic             o_capture_input_two,
    output logic      [1:0]  o_capture_event,
    output logic             o_irq
);

    // =============================================================
    // Register state and bus decode.
    logic [15:0]               mode_reg;
    logic [15:0]               mode_next;
    logic [1:0]                en_reg;
    logic [3:0]                stat_reg;
    logic [3:0]                stat_next;
    logic [3:0]                mask_reg;
    logic                      ap_valid_reg;
    logic                      ap_write_reg;
    logic [7:0]                ap_addr_reg;
    logic [31:0]               rdata_reg;
    logic [1:0]                ti_meta_reg;
    logic [1:0]                ti_sync_reg;
    logic [`TCM_DIV_W-1:0]     div_cnt_reg;
    logic [1:0]                filt_reg;
    logic [1:0]                filt_prev_reg;
    logic [1:0]                ref_reg;
    logic [1:0]                cap_reg;
    logic [`TCM_FLEN_W-1:0]    fcnt_reg [2];
    logic [`TCM_PSC_W-1:0]     psc_cnt_reg [2];
    logic [1:0]                samp_en;
    logic [1:0]                route;
    logic [1:0]                edge_ev;
    logic [1:0]                clr_ev;
    logic [15:0]               lock_mask;
    logic                      take;
    logic                      wr_mode;
    logic                      wr_en;
    logic                      wr_stat;
    logic                      wr_mask;
    logic [31:0]               rd_mux;

    // Address phase is taken on a selected NONSEQ or SEQ transfer of any size; a write also needs a whole word.
    assign take    = i_hsel && i_hready && i_htrans[1];
    assign wr_mode = ap_valid_reg && ap_write_reg && (ap_addr_reg == `TCM_OFF_MODE);
    assign wr_en   = ap_valid_reg && ap_write_reg && (ap_addr_reg == `TCM_OFF_ENABLE);
    assign wr_stat = ap_valid_reg && ap_write_reg && (ap_addr_reg == `TCM_OFF_IRQ_STAT);
    assign wr_mask = ap_valid_reg && ap_write_reg && (ap_addr_reg == `TCM_OFF_IRQ_MASK);

    // Zero wait states and an OKAY response on every transfer.
    assign o_hreadyout = 1'b1;
    assign o_hresp     = 1'b0;
    assign o_hrdata    = rdata_reg;

    // Read mux on the address phase; unmapped offsets read zero.
    assign rd_mux = (i_haddr[7:0] == `TCM_OFF_MODE)     ? {16'h0000, mode_reg} :
                    (i_haddr[7:0] == `TCM_OFF_ENABLE)   ? {30'h0, en_reg} :
                    (i_haddr[7:0] == `TCM_OFF_IRQ_STAT) ? {28'h0000000, stat_reg} :
                    (i_haddr[7:0] == `TCM_OFF_IRQ_MASK) ? {28'h0000000, mask_reg} :
                    (i_haddr[7:0] == `TCM_OFF_STATE)    ? {28'h0000000, ref_reg, filt_reg} :
                    32'h00000000;

    // Select bits of an enabled channel keep their value on a mode write.
    assign mode_next = wr_mode ? ((i_hwdata[15:0] & ~lock_mask) | (mode_reg & lock_mask))
                               : mode_reg;

    // Sticky events; a set in the clearing cycle wins over the clear.
    assign stat_next = (stat_reg & ~(wr_stat ? i_hwdata[3:0] : 4'h0))
                     | {clr_ev, cap_reg};
    assign o_irq     = |(stat_reg & mask_reg);

    // Bus pipeline and read data.
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rstn)
        begin
            ap_valid_reg <= 1'b0;
            ap_write_reg <= 1'b0;
            ap_addr_reg  <= 8'h00;
            rdata_reg    <= 32'h00000000;
        end
        else
        begin
            ap_valid_reg <= take && (i_hsize == `TCM_HSIZE_WORD);
            ap_write_reg <= i_hwrite;
            ap_addr_reg  <= i_haddr[7:0];
            rdata_reg    <= (take && !i_hwrite) ? rd_mux : rdata_reg;
        end
    end

    // Software-visible registers.
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rstn)
        begin
            mode_reg <= `TCM_MODE_RST;
            en_reg   <= `TCM_ENABLE_RST;
            stat_reg <= `TCM_IRQ_RST;
            mask_reg <= `TCM_IRQ_RST;
        end
        else
        begin
            mode_reg <= mode_next;
            en_reg   <= wr_en ? i_hwdata[1:0] : en_reg;
            stat_reg <= stat_next;
            mask_reg <= wr_mask ? i_hwdata[3:0] : mask_reg;
        end
    end

    // Pin synchroniser and free-running sampling divider.
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rstn)
        begin
            ti_meta_reg <= 2'h0;
            ti_sync_reg <= 2'h0;
            div_cnt_reg <= '0;
        end
        else
        begin
            ti_meta_reg <= {i_timer_input_two, i_timer_input_one};
            ti_sync_reg <= ti_meta_reg;
            div_cnt_reg <= div_cnt_reg + 1'b1;
        end
    end

    assign o_ch1_compare_ref   = ref_reg[0];
    assign o_ch2_compare_ref   = ref_reg[1];
    assign o_capture_input_one = filt_reg[0];
    assign o_capture_input_two = filt_reg[1];
    assign o_capture_event     = cap_reg;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);

    // =============================================================
    // Per-channel logic; channel 2 uses the upper byte with the same layout.
    for (genvar c = 0; c < 2; c++)
    begin : g_ch
        tcm_oc_field_t          oc;
        tcm_ic_field_t          ic;
        tcm_filt_cfg_t          fc;
        logic [`TCM_PSC_W-1:0]  psc_lim;
        logic                   cap_on;
        logic                   clr_now;

        // Field views of this channel's byte.
        assign oc = tcm_oc_field_t'(mode_reg[c*`TCM_CH_STRIDE +: `TCM_CH_STRIDE]);
        assign ic = tcm_ic_field_t'(mode_reg[c*`TCM_CH_STRIDE +: `TCM_CH_STRIDE]);
        assign fc = tcm_filt_decode(ic.filt);
        assign lock_mask[c*`TCM_CH_STRIDE +: `TCM_CH_STRIDE] =
            {{(`TCM_CH_STRIDE-`TCM_SEL_W){1'b0}}, {`TCM_SEL_W{en_reg[c]}}};

        // Input routing: direct pin, the other channel's pin, or the trigger.
        assign route[c] = (ic.sel == TCM_SEL_DIRECT) ? ti_sync_reg[c] :
                          (ic.sel == TCM_SEL_CROSS)  ? ti_sync_reg[1-c] :
                          i_internal_trigger_source;

        // Sampling enable every DIV clocks; code zero samples every clock.
        assign samp_en[c] = ((div_cnt_reg & fc.div_mask) == '0);

        // Prescaler terminal count is 2^psc - 1.
        assign psc_lim    = {ic.psc == 2'h3, ic.psc[1], |ic.psc};
        assign cap_on     = en_reg[c] && (ic.sel != TCM_SEL_OUTPUT);
        assign edge_ev[c] = filt_reg[c] && !filt_prev_reg[c];
        assign clr_now    = oc.clr_en && i_filtered_ext_trigger;
        assign clr_ev[c]  = clr_now && ref_reg[c];

        // Filter: flip only after N consecutive differing samples.
        always_ff @(posedge i_clk_sys)
        begin
            if (!i_rstn)
            begin
                fcnt_reg[c]      <= '0;
                filt_reg[c]      <= 1'b0;
                filt_prev_reg[c] <= 1'b0;
            end
            else
            begin
                filt_prev_reg[c] <= filt_reg[c];
                if (samp_en[c] && (route[c] != filt_reg[c]))
                begin
                    if (fcnt_reg[c] + 1'b1 >= fc.len)
                    begin
                        filt_reg[c] <= route[c];
                        fcnt_reg[c] <= '0;
                    end
                    else
                    begin
                        fcnt_reg[c] <= fcnt_reg[c] + 1'b1;
                    end
                end
                else if (samp_en[c])
                begin
                    fcnt_reg[c] <= '0;
                end
            end
        end

        // Capture prescaler counts qualified rising edges.
        always_ff @(posedge i_clk_sys)
        begin
            if (!i_rstn || !cap_on)
            begin
                psc_cnt_reg[c] <= '0;
                cap_reg[c]     <= 1'b0;
            end
            else
            begin
                cap_reg[c] <= edge_ev[c] && (psc_cnt_reg[c] == psc_lim);
                if (edge_ev[c])
                begin
                    psc_cnt_reg[c] <= (psc_cnt_reg[c] == psc_lim) ? '0 : psc_cnt_reg[c] + 1'b1;
                end
            end
        end

        // Compare reference; the external trigger clear has top priority.
        always_ff @(posedge i_clk_sys)
        begin
            if (!i_rstn)
            begin
                ref_reg[c] <= 1'b0;
            end
            else if (clr_now)
            begin
                ref_reg[c] <= 1'b0;
            end
            else if (ic.sel == TCM_SEL_OUTPUT)
            begin
                case (oc.mode)
                    TCM_CMP_FROZEN:       ref_reg[c] <= ref_reg[c];
                    TCM_CMP_SET_ON_MATCH: ref_reg[c] <= ref_reg[c] | i_ch_match[c];
                    TCM_CMP_CLR_ON_MATCH: ref_reg[c] <= ref_reg[c] & ~i_ch_match[c];
                    TCM_CMP_TOGGLE:       ref_reg[c] <= ref_reg[c] ^ i_ch_match[c];
                    TCM_CMP_FORCE_LOW:    ref_reg[c] <= 1'b0;
                    TCM_CMP_FORCE_HIGH:   ref_reg[c] <= 1'b1;
                    TCM_CMP_PWM_ONE:      ref_reg[c] <= i_ch_cnt_below[c];
                    TCM_CMP_PWM_TWO:      ref_reg[c] <= !i_ch_cnt_below[c];
                    default:              ref_reg[c] <= ref_reg[c];
                endcase
            end
        end

        // Checks of the channel's behaviour.
        sequence s_edge_at_limit;
            cap_on && edge_ev[c] && (psc_cnt_reg[c] == psc_lim);
        endsequence

        a_clear_forces_low: assert property (clr_now |=> !ref_reg[c])
            else $error("Reference not cleared by external trigger.");
        a_sel_write_lock: assert property ((wr_mode && en_reg[c]) |=>
            (mode_reg[c*`TCM_CH_STRIDE +: `TCM_SEL_W] ==
             $past(mode_reg[c*`TCM_CH_STRIDE +: `TCM_SEL_W])))
            else $error("Select field changed while channel enabled.");
        a_route_direct: assert property ((ic.sel == TCM_SEL_DIRECT) |->
            (route[c] == $past(c ? i_timer_input_two : i_timer_input_one, 2)))
            else $error("Direct routing picks the wrong timer input.");
        a_route_cross: assert property ((ic.sel == TCM_SEL_CROSS) |->
            (route[c] == $past(c ? i_timer_input_one : i_timer_input_two, 2)))
            else $error("Cross routing picks the wrong timer input.");
        a_psc_capture: assert property (s_edge_at_limit |=> cap_reg[c])
            else $error("Capture missing at prescaler terminal count.");
        a_psc_no_early: assert property ((cap_on && edge_ev[c] &&
            (psc_cnt_reg[c] != psc_lim)) |=> !cap_reg[c])
            else $error("Capture before prescaler terminal count.");
        a_filter_bypass: assert property ((ic.filt == 4'h0 &&
            route[c] != filt_reg[c]) |=> (filt_reg[c] == $past(route[c])))
            else $error("Unfiltered input not followed in one clock.");
        a_filter_length: assert property ($changed(filt_reg[c]) |->
            ($past(fcnt_reg[c]) == $past(fc.len) - 4'h1) && $past(samp_en[c]))
            else $error("Filter output changed before N samples.");
        a_sample_rate: assert property ((samp_en[c] && fc.div_mask == 5'h1F) |->
            (div_cnt_reg == 5'h00))
            else $error("Sampling enable off the divided rate.");
        a_force_high: assert property ((ic.sel == TCM_SEL_OUTPUT &&
            oc.mode == TCM_CMP_FORCE_HIGH && !clr_now) |=> ref_reg[c])
            else $error("Forced-high mode did not drive reference high.");
        a_toggle_match: assert property ((ic.sel == TCM_SEL_OUTPUT &&
            oc.mode == TCM_CMP_TOGGLE && i_ch_match[c] && !clr_now) |=> $changed(ref_reg[c]))
            else $error("Toggle mode did not flip on match.");
    end

endmodule : tcm_chan12_mode

// ### tcm_pin_model.sv
// Behavioural model of the timer input pins and trigger sources.
`timescale 1ns/1ps

module tcm_pin_model
(
    input  wire logic       i_clk_sys,
    input  wire logic [3:0] i_lvl,
    output logic      [3:0] o_pins
);
    // =============================================================
    // Sources
    logic [3:0] pins_reg = 4'h0;

    // Sources settle one clock after the bench asks, on the rising edge the design samples on.
    always @(posedge i_clk_sys)
    begin
        pins_reg <= i_lvl;
    end

    // Order is pin one, pin two, internal trigger, external trigger.
    assign o_pins = pins_reg;
endmodule : tcm_pin_model

// ### tcm_pkg.sv
// Types shared by the channel 1/2 mode configuration block.
package tcm_pkg;

    // =============================================================
    // Compare modes of the reference generator.
    typedef enum logic [2:0] {
        TCM_CMP_FROZEN,
        TCM_CMP_SET_ON_MATCH,
        TCM_CMP_CLR_ON_MATCH,
        TCM_CMP_TOGGLE,
        TCM_CMP_FORCE_LOW,
        TCM_CMP_FORCE_HIGH,
        TCM_CMP_PWM_ONE,
        TCM_CMP_PWM_TWO
    } tcm_cmp_mode_t;

    // Channel direction and input routing.
    typedef enum logic [1:0] {
        TCM_SEL_OUTPUT,
        TCM_SEL_DIRECT,
        TCM_SEL_CROSS,
        TCM_SEL_TRIGGER
    } tcm_sel_t;

    // One channel's byte of the mode register in output compare layout.
    typedef struct packed {
        logic          clr_en;
        tcm_cmp_mode_t mode;
        logic          preload_en;
        logic          fast_en;
        tcm_sel_t      sel;
    } tcm_oc_field_t;

    // One channel's byte of the mode register in input capture layout.
    typedef struct packed {
        logic [3:0] filt;
        logic [1:0] psc;
        tcm_sel_t   sel;
    } tcm_ic_field_t;

    // Decoded filter setting: sample-enable mask (DIV-1) and length N.
    typedef struct packed {
        logic [4:0] div_mask;
        logic [3:0] len;
    } tcm_filt_cfg_t;

    // Filter code table; code 0 samples every clock with no qualification.
    function automatic tcm_filt_cfg_t tcm_filt_decode(input logic [3:0] code);
        tcm_filt_cfg_t r;
        case (code)
            4'h1:    r = '{5'h00, 4'h2};
            4'h2:    r = '{5'h00, 4'h4};
            4'h3:    r = '{5'h00, 4'h8};
            4'h4:    r = '{5'h01, 4'h6};
            4'h5:    r = '{5'h01, 4'h8};
            4'h6:    r = '{5'h03, 4'h6};
            4'h7:    r = '{5'h03, 4'h8};
            4'h8:    r = '{5'h07, 4'h6};
            4'h9:    r = '{5'h07, 4'h8};
            4'hA:    r = '{5'h0F, 4'h5};
            4'hB:    r = '{5'h0F, 4'h6};
            4'hC:    r = '{5'h0F, 4'h8};
            4'hD:    r = '{5'h1F, 4'h5};
            4'hE:    r = '{5'h1F, 4'h6};
            4'hF:    r = '{5'h1F, 4'h8};
            default: r = '{5'h00, 4'h1};
        endcase
        return r;
    endfunction : tcm_filt_decode

endpackage : tcm_pkg

// ### testbench.sv
// Self-checking bench for the channel 1/2 mode configuration block.
`timescale 1ns/1ps

module testbench;
    // =============================================================
    // Signals
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [1:0]  match = 2'h0;
    logic [1:0]  below = 2'h0;
    logic [3:0]  lvl = 4'h0;
    logic [3:0]  pins;
    logic [1:0]  ev;
    logic [1:0]  cap;
    logic [1:0]  refv;
    logic        ready;
    logic        irq;
    logic        hresp;
    logic [31:0] lfsr = 32'h1BE2;
    int          miscompares = 0;
    int          compares = 0;
    int          ev_cnt[2];
    localparam int FN[16] = '{1, 2, 4, 8, 6, 8, 6, 8, 6, 8, 5, 6, 8, 5, 6, 8};
    localparam int FD[16] = '{1, 1, 1, 1, 2, 2, 4, 4, 8, 8, 16, 16, 16, 32, 32, 32};

    // =============================================================
    // Design and partner
    tcm_chan12_mode tcm_chan12_mode_i (
        .i_clk_sys(clk), .i_rstn(rstn), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
        .i_hready(ready), .o_hrdata(hrdata), .o_hreadyout(ready), .o_hresp(hresp),
        .i_timer_input_one(pins[0]), .i_timer_input_two(pins[1]),
        .i_internal_trigger_source(pins[2]), .i_filtered_ext_trigger(pins[3]),
        .i_ch_match(match), .i_ch_cnt_below(below),
        .o_ch1_compare_ref(refv[0]), .o_ch2_compare_ref(refv[1]),
        .o_capture_input_one(cap[0]), .o_capture_input_two(cap[1]),
        .o_capture_event(ev), .o_irq(irq));

    tcm_pin_model tcm_pin_model_i (.i_clk_sys(clk), .i_lvl(lvl), .o_pins(pins));

    // =============================================================
    // Clock, event counter and watchdog
    initial
    begin
        forever #20 clk = ~clk;
    end

    // Capture pulses are counted per channel on every rising edge.
    always @(posedge clk)
    begin
        for (int c = 0; c < 2; c++)
            if (ev[c] === 1'b1)
                ev_cnt[c]++;
    end

    // A hang ends the run after about 50000 clocks.
    initial
    begin
        #2000000;
        miscompares++;
        end_sim();
    end

    // =============================================================
    // Helpers
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    // Source index feeding a channel for a given select code.
    function automatic int src(input int ch, input int s);
        if (s == 3)
            return 2;
        return (((s == 1) ? 1 : 0) ^ ch) ? 0 : 1;
    endfunction : src

    // Reference level expected after a match with the counter flag b.
    function automatic logic exp_ref(input int m, input logic old, input logic b);
        case (m)
            0: return old;
            1, 5: return 1'b1;
            2, 4: return 1'b0;
            3: return ~old;
            6: return b;
            default: return ~b;
        endcase
    endfunction : exp_ref

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    // One single AHB-Lite transfer; read data is taken at the data-phase edge.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge clk);
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        hsel <= 1'b1;
        do @(posedge clk); while (ready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (ready !== 1'b1);
        q = hrdata;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, e);
        chk(hresp, 32'h0);
    endtask : rdc

    task automatic end_sim;
        if (miscompares == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_sim

    // =============================================================
    // Main sequence
    initial
    begin
        logic [15:0] r1;
        logic [15:0] r2;
        logic [15:0] keep;
        logic        e;
        int          lat;
        int          base;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        cyc(2);
        // Reset values, then an unmapped offset that must read zero.
        for (int a = 0; a < 5; a++)
            rdc(8'(a * 4), 32'h0);
        wr(8'h20, 32'hFFFF);
        rdc(8'h20, 32'h0);
        // A byte-sized write must be ignored.
        hsize <= 3'h0;
        wr(8'h0C, 32'hF);
        hsize <= 3'h2;
        rdc(8'h0C, 32'h0);
        // Random mode words; select bits of an enabled channel must hold.
        for (int en = 0; en < 4; en++)
        begin
            lfsr = lfsr_next(lfsr);
            r1 = lfsr[15:0];
            lfsr = lfsr_next(lfsr);
            r2 = lfsr[15:0];
            keep = {6'h0, {2{en[1]}}, 6'h0, {2{en[0]}}};
            wr(8'h04, 32'h0);
            wr(8'h00, {16'h0, r1});
            wr(8'h04, 32'(en));
            wr(8'h00, {16'h0, r2});
            rdc(8'h00, {16'h0, (r2 & ~keep) | (r1 & keep)});
        end
        // Input routing per select code, filter off.
        for (int ch = 0; ch < 2; ch++)
            for (int s = 1; s < 4; s++)
            begin
                wr(8'h04, 32'h0);
                wr(8'h00, 32'(s) << (8 * ch));
                wr(8'h04, 32'h3);
                lvl <= 4'(1 << src(ch, s));
                cyc(6);
                chk(cap[ch], 1'b1);
                lvl <= 4'h7 ^ 4'(1 << src(ch, s));
                cyc(6);
                chk(cap[ch], 1'b0);
                lvl <= 4'h0;
                cyc(6);
            end
        // Prescaler: eight rising events give 8, 4, 2 or 1 captures.
        for (int ch = 0; ch < 2; ch++)
            for (int k = 0; k < 4; k++)
            begin
                wr(8'h04, 32'h0);
                wr(8'h00, 32'((k << 2) | 1) << (8 * ch));
                wr(8'h04, 32'h3);
                base = ev_cnt[ch];
                repeat (8)
                begin
                    lvl <= 4'(1 << src(ch, 1));
                    cyc(4);
                    lvl <= 4'h0;
                    cyc(4);
                end
                cyc(6);
                chk(ev_cnt[ch] - base, 32'(8 >> k));
            end
        // Filter delay for every code on channel 1.
        for (int c = 0; c < 16; c++)
        begin
            wr(8'h04, 32'h0);
            wr(8'h00, 32'(c << 4) | 32'h1);
            wr(8'h04, 32'h1);
            lvl <= 4'h1;
            lat = 0;
            while (cap[0] !== 1'b1 && lat < 400)
            begin
                cyc(1);
                lat++;
            end
            chk(lat >= (FN[c] - 1) * FD[c] + 4 && lat <= FN[c] * FD[c] + 6, 1'b1);
            lvl <= 4'h0;
            cyc(FN[c] * FD[c] + 8);
        end
        // A pulse shorter than eight samples must be swallowed.
        wr(8'h04, 32'h0);
        wr(8'h00, 32'h31);
        wr(8'h04, 32'h1);
        base = ev_cnt[0];
        lvl <= 4'h1;
        cyc(4);
        lvl <= 4'h0;
        cyc(14);
        chk(ev_cnt[0] - base, 32'h0);
        lvl <= 4'h1;
        cyc(12);
        lvl <= 4'h0;
        cyc(14);
        chk(ev_cnt[0] - base, 32'h1);
        // Every compare mode on both channels with random counter flags.
        wr(8'h04, 32'h0);
        for (int ch = 0; ch < 2; ch++)
        begin
            // Earlier scenarios may leave the reference high, so force it low first.
            wr(8'h00, 32'h40 << (8 * ch));
            e = 1'b0;
            for (int m = 0; m < 8; m++)
            begin
                lfsr = lfsr_next(lfsr);
                below <= lfsr[1:0];
                wr(8'h00, 32'(m << 4) << (8 * ch));
                match[ch] <= 1'b1;
                cyc(1);
                match <= 2'h0;
                cyc(2);
                e = exp_ref(m, e, lfsr[ch]);
                chk(refv[ch], e);
            end
        end
        // Trigger clear, its status bits, mask and write-one-to-clear.
        wr(8'h08, 32'hF);
        wr(8'h0C, 32'h0);
        wr(8'h00, 32'hD0D0);
        cyc(2);
        rdc(8'h10, 32'hC);
        lvl <= 4'h8;
        cyc(3);
        chk(refv, 2'h0);
        chk(irq, 1'b0);
        rdc(8'h08, 32'hC);
        wr(8'h0C, 32'h4);
        cyc(1);
        chk(irq, 1'b1);
        lvl <= 4'h0;
        cyc(3);
        chk(refv, 2'h3);
        wr(8'h08, 32'h4);
        cyc(1);
        chk(irq, 1'b0);
        rdc(8'h08, 32'h8);
        wr(8'h00, 32'h5050);
        lvl <= 4'h8;
        cyc(3);
        chk(refv, 2'h3);
        lvl <= 4'h0;
        end_sim();
    end
endmodule : testbench
